/* logic/gtimer_pkg.sv */
package gtimer_pkg;
  // Number of processors sharing the counter, and the width of their identity.
  localparam int NUM_CPU = 4;
  localparam int CPU_W = 2;
  localparam int OFF_W = 5;
  // Block offset inside the private region; the block decodes only the low offset bits.
  localparam logic [31:0] BLOCK_OFFSET = 32'h0000_0200;
  // Register offsets.
  localparam logic [OFF_W-1:0] OFF_CNT_LO = 5'h00;
  localparam logic [OFF_W-1:0] OFF_CNT_HI = 5'h04;
  localparam logic [OFF_W-1:0] OFF_CTL = 5'h08;
  localparam logic [OFF_W-1:0] OFF_FLAG = 5'h0C;
  localparam logic [OFF_W-1:0] OFF_CMP_LO = 5'h10;
  localparam logic [OFF_W-1:0] OFF_CMP_HI = 5'h14;
  localparam logic [OFF_W-1:0] OFF_STEP = 5'h18;
  // Control field positions.
  localparam int BIT_TIMER_EN = 0;
  localparam int BIT_CMP_EN = 1;
  localparam int BIT_IRQ_EN = 2;
  localparam int BIT_AUTO_INC = 3;
  localparam int PRE_LSB = 8;
  localparam int PRE_W = 8;
  localparam int BIT_EVENT = 0;
  // Reset values.
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [63:0] RST_DWORD = 64'h0000_0000_0000_0000;
  localparam logic [PRE_W-1:0] RST_PRE = 8'h00;
  localparam logic RST_BIT = 1'b0;
endpackage

/* logic/shared_global_timer.sv */
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// R1: One shared 64-bit up-counter keeps counting after any event or interrupt.
// R2: Each processor has its own comparator driving its private timer interrupt.
// R3: A comparator matches when the count is greater than or equal to it.
// R4: Debug halt of any processor never stops the shared counter.
// R5: Counter and comparators advance on the peripheral clock enable only.
// R6: After reset only secure accesses are honoured until non-secure access is granted.
// R7: Peripheral reset clears all seven registers; they sit at fixed block offsets.
// R8: Software reaches count halves with separate 32-bit accesses, never paired transfers.
// R9: Software changes the count: disable, write low, write high, re-enable.
// R10: Software reads high, low, high again, repeating low until highs agree.
// R11: An 8-bit prescaler in bits 15:8 stretches steps; bits 31:16, 7:4 reserved.
// R12: With auto-increment clear a match only sets the event flag.
// R13: With auto-increment set each match adds the step value to the comparator.
// R14: The auto-increment bit is held separately for each processor.
// R15: Per-processor interrupt enable makes a set event flag raise that interrupt.
// R16: Comparison happens only while that processor's compare enable is set.
// R17: The counter steps only while timer enable is one; registers stay accessible.
// R18: The event flag is sticky, set on match, cleared by writing one.
// R19: Count steps every prescaler-plus-one enabled ticks; comparators test on each step.
// R20: Banked registers are selected by the identity of the accessing processor.
module shared_global_timer (
  // Clock, peripheral reset and peripheral clock enable.
  input wire logic I_SYS_CLK,
  input wire logic I_ARST_N,
  input wire logic I_PERIPH_CLK_EN,
  // Security access control.
  input wire logic I_NS_GRANT,
  // Register access port.
  input wire logic I_REQ,
  input wire logic I_WR,
  input wire logic [gtimer_pkg::OFF_W-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic [gtimer_pkg::CPU_W-1:0] I_CPU_ID,
  input wire logic I_SECURE,
  // Register answer.
  output logic O_ACK,
  output logic [31:0] O_RDATA,
  output logic O_ERR,
  // Private timer interrupts, one per processor.
  output logic [gtimer_pkg::NUM_CPU-1:0] O_TIMER_IRQ
);

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic is_mapped(input logic [gtimer_pkg::OFF_W-1:0] off);
    is_mapped = (off == gtimer_pkg::OFF_CNT_LO) || (off == gtimer_pkg::OFF_CNT_HI) ||
                (off == gtimer_pkg::OFF_CTL) || (off == gtimer_pkg::OFF_FLAG) ||
                (off == gtimer_pkg::OFF_CMP_LO) || (off == gtimer_pkg::OFF_CMP_HI) ||
                (off == gtimer_pkg::OFF_STEP);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  logic [63:0] count_ff;
  logic [63:0] nxt_count;
  logic timer_en_ff;
  logic nxt_timer_en;
  logic [gtimer_pkg::PRE_W-1:0] pre_ff;
  logic [gtimer_pkg::PRE_W-1:0] nxt_pre;
  logic [gtimer_pkg::PRE_W-1:0] pre_cnt_ff;
  logic [gtimer_pkg::PRE_W-1:0] nxt_pre_cnt;
  logic [63:0] comp_ff [gtimer_pkg::NUM_CPU];
  logic [63:0] nxt_comp [gtimer_pkg::NUM_CPU];
  logic [31:0] step_ff [gtimer_pkg::NUM_CPU];
  logic [31:0] nxt_step [gtimer_pkg::NUM_CPU];
  logic [gtimer_pkg::NUM_CPU-1:0] cmp_en_ff;
  logic [gtimer_pkg::NUM_CPU-1:0] nxt_cmp_en;
  logic [gtimer_pkg::NUM_CPU-1:0] irq_en_ff;
  logic [gtimer_pkg::NUM_CPU-1:0] nxt_irq_en;
  logic [gtimer_pkg::NUM_CPU-1:0] auto_ff;
  logic [gtimer_pkg::NUM_CPU-1:0] nxt_auto;
  logic [gtimer_pkg::NUM_CPU-1:0] flag_ff;
  logic [gtimer_pkg::NUM_CPU-1:0] nxt_flag;
  logic [gtimer_pkg::NUM_CPU-1:0] irq_ff;
  logic [gtimer_pkg::NUM_CPU-1:0] nxt_irq;
  logic ack_ff;
  logic nxt_ack;
  logic err_ff;
  logic nxt_err;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  logic acc_ok;
  logic wr;
  logic tick;
  logic step_now;
  logic [gtimer_pkg::NUM_CPU-1:0] match;
  logic [gtimer_pkg::NUM_CPU-1:0] clr_req;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    acc_ok = I_SECURE | I_NS_GRANT; // R6
    wr = I_REQ & I_WR & acc_ok & is_mapped(I_ADDR);
    // The clock enable and timer enable are the only gates on the tick; debug halt is deliberately not an input.
    tick = I_PERIPH_CLK_EN & timer_en_ff; // R5 R17 R4
    // Greater-or-equal keeps a stale prescale count from running a full wrap after a rewrite.
    step_now = tick & (pre_cnt_ff >= pre_ff); // R11 R19
    nxt_count = count_ff;
    nxt_timer_en = timer_en_ff;
    nxt_pre = pre_ff;
    nxt_pre_cnt = pre_cnt_ff;
    nxt_cmp_en = cmp_en_ff;
    nxt_irq_en = irq_en_ff;
    nxt_auto = auto_ff;
    nxt_flag = flag_ff;
    match = '0;
    clr_req = '0;
    for (int c = 0; c < gtimer_pkg::NUM_CPU; c++) begin
      nxt_comp[c] = comp_ff[c];
      nxt_step[c] = step_ff[c];
    end
    if (!timer_en_ff) begin
      nxt_pre_cnt = gtimer_pkg::RST_PRE;
    end else if (tick) begin
      nxt_pre_cnt = step_now ? gtimer_pkg::RST_PRE : pre_cnt_ff + 8'h01; // R19
    end
    if (step_now) begin
      nxt_count = count_ff + 64'h0000_0000_0000_0001; // R1
    end
    for (int c = 0; c < gtimer_pkg::NUM_CPU; c++) begin
      match[c] = step_now & cmp_en_ff[c] & (count_ff >= comp_ff[c]); // R3 R16 R19 R2
      if (match[c] && auto_ff[c]) begin
        nxt_comp[c] = comp_ff[c] + {32'h0000_0000, step_ff[c]}; // R13
      end
    end
    // A software write to the count or comparator wins over the hardware update.
    if (wr) begin
      case (I_ADDR)
        gtimer_pkg::OFF_CNT_LO: begin
          nxt_count[31:0] = I_WDATA;
        end
        gtimer_pkg::OFF_CNT_HI: begin
          nxt_count[63:32] = I_WDATA;
        end
        gtimer_pkg::OFF_CTL: begin
          nxt_timer_en = I_WDATA[gtimer_pkg::BIT_TIMER_EN];
          nxt_pre = I_WDATA[gtimer_pkg::PRE_LSB +: gtimer_pkg::PRE_W]; // R11
          nxt_cmp_en[I_CPU_ID] = I_WDATA[gtimer_pkg::BIT_CMP_EN]; // R20
          nxt_irq_en[I_CPU_ID] = I_WDATA[gtimer_pkg::BIT_IRQ_EN]; // R15
          nxt_auto[I_CPU_ID] = I_WDATA[gtimer_pkg::BIT_AUTO_INC]; // R14
        end
        gtimer_pkg::OFF_FLAG: begin
          clr_req[I_CPU_ID] = I_WDATA[gtimer_pkg::BIT_EVENT]; // R18
        end
        gtimer_pkg::OFF_CMP_LO: begin
          nxt_comp[I_CPU_ID][31:0] = I_WDATA; // R20
        end
        gtimer_pkg::OFF_CMP_HI: begin
          nxt_comp[I_CPU_ID][63:32] = I_WDATA;
        end
        gtimer_pkg::OFF_STEP: begin
          nxt_step[I_CPU_ID] = I_WDATA;
        end
        default: begin
        end
      endcase
    end
    for (int c = 0; c < gtimer_pkg::NUM_CPU; c++) begin
      // A match in the same cycle as a clear keeps the flag set.
      nxt_flag[c] = match[c] | (flag_ff[c] & ~clr_req[c]); // R18 R12
      nxt_irq[c] = nxt_flag[c] & nxt_irq_en[c]; // R15 R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    rd_word = gtimer_pkg::RST_WORD;
    case (I_ADDR)
      gtimer_pkg::OFF_CNT_LO: rd_word = count_ff[31:0];
      gtimer_pkg::OFF_CNT_HI: rd_word = count_ff[63:32];
      gtimer_pkg::OFF_CTL: begin
        rd_word[gtimer_pkg::PRE_LSB +: gtimer_pkg::PRE_W] = pre_ff; // R11
        rd_word[gtimer_pkg::BIT_AUTO_INC] = auto_ff[I_CPU_ID];
        rd_word[gtimer_pkg::BIT_IRQ_EN] = irq_en_ff[I_CPU_ID];
        rd_word[gtimer_pkg::BIT_CMP_EN] = cmp_en_ff[I_CPU_ID];
        rd_word[gtimer_pkg::BIT_TIMER_EN] = timer_en_ff;
      end
      gtimer_pkg::OFF_FLAG: rd_word[gtimer_pkg::BIT_EVENT] = flag_ff[I_CPU_ID]; // R20
      gtimer_pkg::OFF_CMP_LO: rd_word = comp_ff[I_CPU_ID][31:0];
      gtimer_pkg::OFF_CMP_HI: rd_word = comp_ff[I_CPU_ID][63:32];
      gtimer_pkg::OFF_STEP: rd_word = step_ff[I_CPU_ID];
      default: rd_word = gtimer_pkg::RST_WORD;
    endcase
    nxt_ack = I_REQ;
    nxt_err = I_REQ & ~(acc_ok & is_mapped(I_ADDR)); // R6
    nxt_rdata = (I_REQ & acc_ok) ? rd_word : gtimer_pkg::RST_WORD;
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      count_ff <= gtimer_pkg::RST_DWORD; // R7
      timer_en_ff <= gtimer_pkg::RST_BIT;
      pre_ff <= gtimer_pkg::RST_PRE;
      pre_cnt_ff <= gtimer_pkg::RST_PRE;
      cmp_en_ff <= '0;
      irq_en_ff <= '0;
      auto_ff <= '0;
      flag_ff <= '0;
      irq_ff <= '0;
      ack_ff <= gtimer_pkg::RST_BIT;
      err_ff <= gtimer_pkg::RST_BIT;
      rdata_ff <= gtimer_pkg::RST_WORD;
      for (int c = 0; c < gtimer_pkg::NUM_CPU; c++) begin
        comp_ff[c] <= gtimer_pkg::RST_DWORD;
        step_ff[c] <= gtimer_pkg::RST_WORD;
      end
    end else begin
      count_ff <= nxt_count;
      timer_en_ff <= nxt_timer_en;
      pre_ff <= nxt_pre;
      pre_cnt_ff <= nxt_pre_cnt;
      cmp_en_ff <= nxt_cmp_en;
      irq_en_ff <= nxt_irq_en;
      auto_ff <= nxt_auto;
      flag_ff <= nxt_flag;
      irq_ff <= nxt_irq;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
      rdata_ff <= nxt_rdata;
      for (int c = 0; c < gtimer_pkg::NUM_CPU; c++) begin
        comp_ff[c] <= nxt_comp[c];
        step_ff[c] <= nxt_step[c];
      end
    end
  end

  assign O_ACK = ack_ff;
  assign O_ERR = err_ff;
  assign O_RDATA = rdata_ff;
  assign O_TIMER_IRQ = irq_ff;

  ////////////////////////////////////////////////////////////////////////////////

  property p_count_step;
    @(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    step_now && !(wr && (I_ADDR == gtimer_pkg::OFF_CNT_LO || I_ADDR == gtimer_pkg::OFF_CNT_HI))
    |=> count_ff == $past(count_ff) + 64'h0000_0000_0000_0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step"); // R1

  property p_count_hold;
    @(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    !timer_en_ff && !(wr && (I_ADDR == gtimer_pkg::OFF_CNT_LO || I_ADDR == gtimer_pkg::OFF_CNT_HI))
    |=> $stable(count_ff);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved while disabled"); // R17

  property p_prescale;
    @(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    step_now && pre_ff != 8'h00 && !(wr && I_ADDR == gtimer_pkg::OFF_CTL) |=> !step_now;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler stepped too soon"); // R19

  property p_ge_match;
    @(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    step_now && cmp_en_ff[1] && count_ff > comp_ff[1] |=> flag_ff[1];
  endproperty
  a_ge_match: assert property (p_ge_match) else $error("greater count did not match"); // R3

  property p_gate;
    @(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    !cmp_en_ff[0] && !flag_ff[0] |=> !flag_ff[0];
  endproperty
  a_gate: assert property (p_gate) else $error("flag set with compare disabled"); // R16

  property p_sticky;
    @(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    flag_ff[2] && !(wr && I_ADDR == gtimer_pkg::OFF_FLAG && I_CPU_ID == 2'h2 && I_WDATA[0])
    |=> flag_ff[2];
  endproperty
  a_sticky: assert property (p_sticky) else $error("event flag dropped by itself"); // R18

  property p_auto;
    @(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    match[2] && auto_ff[2] && !wr |=> comp_ff[2] == $past(comp_ff[2]) + {32'h0, $past(step_ff[2])};
  endproperty
  a_auto: assert property (p_auto) else $error("comparator not advanced"); // R13

  property p_single;
    @(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    match[1] && !auto_ff[1] && !wr |=> $stable(comp_ff[1]) && flag_ff[1];
  endproperty
  a_single: assert property (p_single) else $error("single shot changed comparator"); // R12

  property p_irq;
    @(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    1'b1 |-> O_TIMER_IRQ == (flag_ff & irq_en_ff);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // R15

  property p_nonsecure;
    @(posedge I_SYS_CLK) disable iff (!I_ARST_N)
    I_REQ && !I_SECURE && !I_NS_GRANT |=> O_ACK && O_ERR && O_RDATA == 32'h0000_0000
      && $stable(timer_en_ff) && $stable(pre_ff) && $stable(cmp_en_ff) && $stable(step_ff[0]);
  endproperty
  a_nonsecure: assert property (p_nonsecure) else $error("non-secure access honoured"); // R6

endmodule

/* testbench/gtimer_cpu_model.sv */
module gtimer_cpu_model (
  // Clock and register answer.
  input wire logic i_clk,
  input wire logic i_ack,
  input wire logic [31:0] i_rdata,
  input wire logic i_err,
  // Register request.
  output logic o_req,
  output logic o_wr,
  output logic [gtimer_pkg::OFF_W-1:0] o_addr,
  output logic [31:0] o_wdata,
  output logic [gtimer_pkg::CPU_W-1:0] o_cpu_id,
  output logic o_secure
);
  timeunit 1ns;
  timeprecision 1ns;
  // Set when an access is never answered or a count read never settles.
  bit lost = 1'b0;
  initial begin
    o_req = 1'b0;
    o_wr = 1'b0;
    o_addr = 5'h1F;
    o_wdata = 32'h0;
    o_cpu_id = 2'h0;
    o_secure = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Every access is one 32-bit word; paired word transfers are never issued.
  task automatic access(input logic w, input logic [1:0] c, input logic s,
      input logic [4:0] a, input logic [31:0] d, output logic [31:0] rd,
      output logic e, output bit ok);
    int n;
    @(negedge i_clk);
    o_req = 1'b1;
    o_wr = w;
    o_addr = a;
    o_wdata = d;
    o_cpu_id = c;
    o_secure = s;
    @(negedge i_clk);
    o_req = 1'b0;
    // Released lines show the inverse so a stale value is never mistaken for data.
    o_addr = ~a;
    o_wdata = ~d;
    n = 0;
    while (i_ack !== 1'b1 && n < 4) begin
      @(negedge i_clk);
      n++;
    end
    ok = (i_ack === 1'b1);
    if (!ok) begin
      lost = 1'b1;
    end
    rd = i_rdata;
    e = i_err;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic set_count(input logic [1:0] c, input logic [63:0] v, input logic [31:0] ctl);
    logic [31:0] rd;
    logic e;
    bit ok;
    access(1'b1, c, 1'b1, 5'h08, ctl & 32'hFFFF_FFFE, rd, e, ok);
    access(1'b1, c, 1'b1, 5'h00, v[31:0], rd, e, ok);
    access(1'b1, c, 1'b1, 5'h04, v[63:32], rd, e, ok);
    access(1'b1, c, 1'b1, 5'h08, ctl, rd, e, ok);
  endtask
  // The halves are not captured together, so the high word is read on both sides.
  task automatic read_count(input logic [1:0] c, output logic [63:0] v);
    logic [31:0] hi;
    logic [31:0] hi2;
    logic [31:0] lo;
    logic e;
    bit ok;
    bit agreed;
    agreed = 1'b0;
    access(1'b0, c, 1'b1, 5'h04, 32'h0, hi, e, ok);
    for (int n = 0; n < 4; n++) begin
      access(1'b0, c, 1'b1, 5'h00, 32'h0, lo, e, ok);
      access(1'b0, c, 1'b1, 5'h04, 32'h0, hi2, e, ok);
      if (hi2 === hi) begin
        agreed = 1'b1;
        break;
      end
      hi = hi2;
    end
    if (!agreed) begin
      lost = 1'b1;
    end
    v = {hi, lo};
  endtask
endmodule

/* testbench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic w;
    logic [1:0] c;
    logic s;
    logic [4:0] a;
    logic [31:0] d;
    logic [31:0] rd;
    logic e;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pclk_en = 1'b1;
  logic grant = 1'b0;
  logic req, wr, sec, ack, err;
  logic [4:0] addr;
  logic [31:0] wdata, rdata;
  logic [1:0] id;
  logic [3:0] irq;
  logic [63:0] cnt;
  int fails = 0;
  int samples_checked = 0;
  int n;
  row_t rows [16] = '{
    '{1'h0, 2'h0, 1'h1, 5'h08, 32'h0, 32'h0, 1'h0},
    '{1'h0, 2'h3, 1'h1, 5'h0C, 32'h0, 32'h0, 1'h0},
    '{1'h0, 2'h1, 1'h1, 5'h14, 32'h0, 32'h0, 1'h0},
    '{1'h0, 2'h2, 1'h1, 5'h18, 32'h0, 32'h0, 1'h0},
    '{1'h1, 2'h0, 1'h1, 5'h08, 32'hFFFF_FFFE, 32'h0, 1'h0},
    '{1'h0, 2'h0, 1'h1, 5'h08, 32'h0, 32'h0000_FF0E, 1'h0},
    '{1'h0, 2'h1, 1'h1, 5'h08, 32'h0, 32'h0000_FF00, 1'h0},
    '{1'h1, 2'h1, 1'h1, 5'h18, 32'h5, 32'h0, 1'h0},
    '{1'h0, 2'h0, 1'h1, 5'h18, 32'h0, 32'h0, 1'h0},
    '{1'h0, 2'h1, 1'h1, 5'h18, 32'h0, 32'h5, 1'h0},
    '{1'h0, 2'h0, 1'h1, 5'h1C, 32'h0, 32'h0, 1'h1},
    '{1'h0, 2'h0, 1'h0, 5'h08, 32'h0, 32'h0, 1'h1},
    '{1'h1, 2'h0, 1'h0, 5'h08, 32'h0000_FF0F, 32'h0, 1'h1},
    '{1'h1, 2'h0, 1'h1, 5'h08, 32'h0, 32'h0000_FF0E, 1'h0},
    '{1'h1, 2'h0, 1'h1, 5'h00, 32'h1234_5678, 32'h0, 1'h0},
    '{1'h0, 2'h0, 1'h1, 5'h00, 32'h0, 32'h1234_5678, 1'h0}
  };
  always #50 clk = ~clk;
  shared_global_timer dut (.I_SYS_CLK(clk), .I_ARST_N(rst_n), .I_PERIPH_CLK_EN(pclk_en),
    .I_NS_GRANT(grant), .I_REQ(req), .I_WR(wr), .I_ADDR(addr), .I_WDATA(wdata),
    .I_CPU_ID(id), .I_SECURE(sec), .O_ACK(ack), .O_RDATA(rdata), .O_ERR(err),
    .O_TIMER_IRQ(irq));
  gtimer_cpu_model cpu (.i_clk(clk), .i_ack(ack), .i_rdata(rdata), .i_err(err),
    .o_req(req), .o_wr(wr), .o_addr(addr), .o_wdata(wdata), .o_cpu_id(id), .o_secure(sec));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input row_t r);
    logic [31:0] rd;
    logic e;
    bit ok;
    cpu.access(r.w, r.c, r.s, r.a, r.d, rd, e, ok);
    if (!ok) begin
      fails++;
      results();
    end
    chk32("read data", r.rd, rd);
    chk4("error flag", {3'h0, r.e}, {3'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    chk4("interrupts", 4'h0, irq);
    foreach (rows[i]) acc(rows[i]);
    // Periodic compare on processor 2, greater-or-equal compare on processor 1.
    acc('{1'h1, 2'h2, 1'h1, 5'h10, 32'h5, 32'h0, 1'h0});
    acc('{1'h1, 2'h2, 1'h1, 5'h14, 32'h2, 32'h0, 1'h0});
    acc('{1'h1, 2'h2, 1'h1, 5'h18, 32'h10, 32'h0, 1'h0});
    acc('{1'h1, 2'h1, 1'h1, 5'h08, 32'h2, 32'h0, 1'h0});
    cpu.set_count(2'h2, 64'h0000_0001_FFFF_FFF0, 32'h0000_000F);
    n = 0;
    while (irq[2] !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk4("interrupts", 4'h4, irq);
    acc('{1'h1, 2'h2, 1'h1, 5'h08, 32'hE, 32'hF, 1'h0});
    acc('{1'h0, 2'h2, 1'h1, 5'h10, 32'h0, 32'h15, 1'h0});
    acc('{1'h0, 2'h2, 1'h1, 5'h14, 32'h0, 32'h2, 1'h0});
    cpu.read_count(2'h2, cnt);
    chk32("count high", 32'h2, cnt[63:32]);
    chk32("count low", 32'h8, cnt[31:0]);
    acc('{1'h0, 2'h1, 1'h1, 5'h0C, 32'h0, 32'h1, 1'h0});
    acc('{1'h0, 2'h0, 1'h1, 5'h0C, 32'h0, 32'h0, 1'h0});
    acc('{1'h0, 2'h1, 1'h1, 5'h10, 32'h0, 32'h0, 1'h0});
    acc('{1'h1, 2'h2, 1'h1, 5'h0C, 32'h0, 32'h1, 1'h0});
    acc('{1'h1, 2'h2, 1'h1, 5'h0C, 32'h1, 32'h1, 1'h0});
    acc('{1'h0, 2'h2, 1'h1, 5'h0C, 32'h0, 32'h0, 1'h0});
    chk4("interrupts", 4'h0, irq);
    // Prescaler 3: eight ticks give two steps, and no tick means no step.
    pclk_en = 1'b0;
    cpu.set_count(2'h0, 64'h0, 32'h0000_0301);
    pclk_en = 1'b1;
    repeat (8) @(negedge clk);
    pclk_en = 1'b0;
    repeat (5) @(negedge clk);
    acc('{1'h0, 2'h0, 1'h1, 5'h00, 32'h0, 32'h2, 1'h0});
    pclk_en = 1'b1;
    grant = 1'b1;
    acc('{1'h0, 2'h3, 1'h0, 5'h08, 32'h0, 32'h0000_0301, 1'h0});
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    acc('{1'h0, 2'h0, 1'h1, 5'h08, 32'h0, 32'h0, 1'h0});
    acc('{1'h0, 2'h1, 1'h1, 5'h0C, 32'h0, 32'h0, 1'h0});
    chk4("bus timeouts", 4'h0, {3'h0, cpu.lost});
    results();
  end
endmodule
